// [logic/cif_defines.vh]
`ifndef CIF_DEFINES_VH
`define CIF_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CIF_OFF_FLAGS      12'h000
`define CIF_OFF_INT_STAT   12'h004
`define CIF_OFF_INT_MASK   12'h008
`define CIF_OFF_CTRL       12'h00c
`define CIF_OFF_ERR_SRC    12'h010

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define CIF_BIT_RX0        0
`define CIF_BIT_RX1        1
`define CIF_BIT_TX0        2
`define CIF_BIT_TX1        3
`define CIF_BIT_TX2        4
`define CIF_BIT_ERR        5
`define CIF_BIT_WAKE       6
`define CIF_BIT_BAD        7

// ----------------------------------------------------------------
// Control bit positions
// ----------------------------------------------------------------
`define CIF_CTRL_WAKE_EN   0
`define CIF_CTRL_FILT_EN   1

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define CIF_NUM_FLAGS      8
`define CIF_NUM_ERR_SRC    5
`define CIF_RST_FLAGS      8'h00
`define CIF_RST_INT_STAT   8'h00
`define CIF_RST_INT_MASK   8'h00
`define CIF_RST_CTRL       2'h1
`define CIF_RST_ERR_SRC    5'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CIF_CLK_MHZ        10
`define CIF_WAKE_FILT_NS   500
`define CIF_WAKE_FILT_CYC  ((`CIF_WAKE_FILT_NS * `CIF_CLK_MHZ + 999) / 1000)

`endif

// [logic/cif_flag_cell.v]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// One sticky flag: hardware set beats any clear in the same cycle
// ----------------------------------------------------------------
module cif_flag_cell (
  input  wire clk_sys,
  input  wire resetn,
  input  wire set_evt,
  input  wire sw_set,
  input  wire sw_clr,
  output reg  flag_reg
);

  wire flag_next;

  assign flag_next = set_evt | sw_set | (flag_reg & ~sw_clr);

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

endmodule // cif_flag_cell

// [logic/cif_can_flags.v]
`timescale 1ns/1ps
`include "cif_defines.vh"

// Summary of operation
// [R1] Bit 7 latches invalid received message
// [R2] Bit 6 latches bus activity wake-up
// [R3] Bit 5 latches OR of error sources
// [R4] Bit 4 latches transmit buffer two done
// [R5] Bit 3 latches transmit buffer one done
// [R6] Bit 2 latches transmit buffer zero done
// [R7] Bit 1 latches receive buffer one full
// [R8] Bit 0 latches receive buffer zero full
// [R9] Flags sticky until zero written; event wins

module cif_can_flags (
  input  wire        clk_sys,
  input  wire        resetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // Events from the protocol engine and buffers
  input  wire        bad_msg_evt,
  input  wire        can_rx,
  input  wire [4:0]  err_src_evt,
  input  wire [2:0]  tx_done_evt,
  input  wire [1:0]  rx_full_evt,
  // Outputs
  output wire [7:0]  can_event_flags,
  output wire [2:0]  tx_buf_free,
  output wire        irq
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      hit = (addr[11:2] == off[11:2]);
    end
  endfunction

  function mapped;
    input [11:0] addr;
    begin
      mapped = hit(addr, `CIF_OFF_FLAGS) |
               hit(addr, `CIF_OFF_INT_STAT) |
               hit(addr, `CIF_OFF_INT_MASK) |
               hit(addr, `CIF_OFF_CTRL) |
               hit(addr, `CIF_OFF_ERR_SRC);
    end
  endfunction

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // One wait state so that read data can come straight from a flop.
  reg         pready_reg;
  wire        access;
  wire        done;
  wire        wr_done;
  wire        rd_done;

  assign access  = psel & penable;
  assign pready  = pready_reg;
  assign done    = access & pready_reg;
  assign wr_done = done & pwrite & ~pslverr;
  assign rd_done = done & ~pwrite & ~pslverr;

  // Byte lane 0 holds every implemented bit
  wire        wr_lane0;
  assign wr_lane0 = wr_done & pstrb[0];

  wire        wr_flags;
  wire        wr_mask;
  wire        wr_ctrl;
  wire        rd_stat;
  wire        rd_err;

  assign wr_flags = wr_lane0 & hit(paddr, `CIF_OFF_FLAGS);
  assign wr_mask  = wr_lane0 & hit(paddr, `CIF_OFF_INT_MASK);
  assign wr_ctrl  = wr_lane0 & hit(paddr, `CIF_OFF_CTRL);
  assign rd_stat  = rd_done & hit(paddr, `CIF_OFF_INT_STAT);
  assign rd_err   = rd_done & hit(paddr, `CIF_OFF_ERR_SRC);

  // ----------------------------------------------------------------
  // Control and mask registers
  // ----------------------------------------------------------------
  reg  [1:0] ctrl_reg;
  reg  [7:0] int_mask_reg;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg     <= `CIF_RST_CTRL;
      int_mask_reg <= `CIF_RST_INT_MASK;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= pwdata[1:0];
      end
      if (wr_mask) begin
        int_mask_reg <= pwdata[7:0];
      end
    end
  end

  wire wake_en;
  wire filt_en;
  assign wake_en = ctrl_reg[`CIF_CTRL_WAKE_EN];
  assign filt_en = ctrl_reg[`CIF_CTRL_FILT_EN];

  // ----------------------------------------------------------------
  // Wake-up detection
  // ----------------------------------------------------------------
  // Activity is a recessive-to-dominant edge on the receive line.
  // The optional filter ignores glitches shorter than the filter time,
  // trading a few cycles of latency for noise immunity.
  localparam integer FILT_CYC_INT = `CIF_WAKE_FILT_CYC;
  localparam [3:0]   FILT_CYC     = FILT_CYC_INT[3:0];

  reg        rx_prev_reg;
  reg  [3:0] low_cnt_reg;
  reg        low_seen_reg;
  wire       rx_fall;
  wire       filt_hit;
  wire       wake_evt;

  assign rx_fall  = rx_prev_reg & ~can_rx;
  assign filt_hit = ~can_rx & ~low_seen_reg & (low_cnt_reg == FILT_CYC - 4'd1);

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_prev_reg  <= 1'b1;
      low_cnt_reg  <= 4'h0;
      low_seen_reg <= 1'b0;
    end else begin
      rx_prev_reg <= can_rx;
      if (can_rx) begin
        low_cnt_reg  <= 4'h0;
        low_seen_reg <= 1'b0;
      end else if (filt_hit) begin
        low_seen_reg <= 1'b1;
      end else if (!low_seen_reg) begin
        low_cnt_reg <= low_cnt_reg + 4'd1;
      end
    end
  end

  assign wake_evt = wake_en & (filt_en ? filt_hit : rx_fall); // [R2]

  // ----------------------------------------------------------------
  // Error sources
  // ----------------------------------------------------------------
  // Any source sets the single module error flag; the latch below
  // lets software see which ones fired since it last looked.
  wire       err_evt;
  reg  [4:0] err_src_reg;

  assign err_evt = |err_src_evt; // [R3]

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      err_src_reg <= `CIF_RST_ERR_SRC;
    end else begin
      err_src_reg <= err_src_evt | (err_src_reg & ~({5{rd_err}} & prdata[4:0]));
    end
  end

  // ----------------------------------------------------------------
  // Event vector
  // ----------------------------------------------------------------
  wire [7:0] evt;

  assign evt[`CIF_BIT_BAD]  = bad_msg_evt;    // [R1]
  assign evt[`CIF_BIT_WAKE] = wake_evt;       // [R2]
  assign evt[`CIF_BIT_ERR]  = err_evt;        // [R3]
  assign evt[`CIF_BIT_TX2]  = tx_done_evt[2]; // [R4]
  assign evt[`CIF_BIT_TX1]  = tx_done_evt[1]; // [R5]
  assign evt[`CIF_BIT_TX0]  = tx_done_evt[0]; // [R6]
  assign evt[`CIF_BIT_RX1]  = rx_full_evt[1]; // [R7]
  assign evt[`CIF_BIT_RX0]  = rx_full_evt[0]; // [R8]

  // ----------------------------------------------------------------
  // Flag and interrupt status cells
  // ----------------------------------------------------------------
  // Flags: writing 0 clears, writing 1 sets (software-raised event).
  // Status: a read clears only the bits it returned, so an event taken
  // after the read data was captured waits for the next read.
  wire [7:0] flag_q;
  wire [7:0] stat_q;

  genvar i;
  generate
    for (i = 0; i < `CIF_NUM_FLAGS; i = i + 1) begin : g_flag
      cif_flag_cell u_flag (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .set_evt  (evt[i]),
        .sw_set   (wr_flags & pwdata[i]),
        .sw_clr   (wr_flags & ~pwdata[i]),
        .flag_reg (flag_q[i])
      ); // [R9]

      cif_flag_cell u_stat (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .set_evt  (evt[i]),
        .sw_set   (1'b0),
        .sw_clr   (rd_stat & prdata[i]),
        .flag_reg (stat_q[i])
      );
    end
  endgenerate

  assign can_event_flags = flag_q;
  assign tx_buf_free     = flag_q[`CIF_BIT_TX2:`CIF_BIT_TX0]; // [R4] [R5] [R6]
  assign irq             = |(stat_q & int_mask_reg);

  // ----------------------------------------------------------------
  // Read data and answer
  // ----------------------------------------------------------------
  reg [31:0] rdata_next;

  always @* begin
    rdata_next = 32'h0000_0000;
    if (hit(paddr, `CIF_OFF_FLAGS)) begin
      rdata_next[7:0] = flag_q;
    end else if (hit(paddr, `CIF_OFF_INT_STAT)) begin
      rdata_next[7:0] = stat_q;
    end else if (hit(paddr, `CIF_OFF_INT_MASK)) begin
      rdata_next[7:0] = int_mask_reg;
    end else if (hit(paddr, `CIF_OFF_CTRL)) begin
      rdata_next[1:0] = ctrl_reg;
    end else if (hit(paddr, `CIF_OFF_ERR_SRC)) begin
      rdata_next[4:0] = err_src_reg;
    end
  end

  // Read data is captured in the wait cycle, so a status bit that sets
  // in the completing cycle is kept for the next read, not lost.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pready_reg <= 1'b0;
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
    end else begin
      if (access && !pready_reg) begin
        pready_reg <= 1'b1;
        pslverr    <= ~mapped(paddr);
        prdata     <= pwrite ? 32'h0000_0000 : rdata_next;
      end else begin
        pready_reg <= 1'b0;
        pslverr    <= 1'b0;
      end
    end
  end

endmodule // cif_can_flags

// [bench/cif_flags_properties.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Event flag checker
// ----------------------------------------------------------------
module cif_flags_properties (
  input wire        clk_sys,
  input wire        resetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        bad_msg_evt,
  input wire        can_rx,
  input wire [4:0]  err_src_evt,
  input wire [2:0]  tx_done_evt,
  input wire [1:0]  rx_full_evt,
  input wire [7:0]  can_event_flags
);
  wire       wr_flags = psel && penable && pwrite && pready && paddr[11:2] == 10'h000 && pstrb[0];
  wire [7:0] fl       = can_event_flags;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_quiet;
    !bad_msg_evt && err_src_evt == 5'h00 && tx_done_evt == 3'h0 && rx_full_evt == 2'h0;
  endsequence
  sequence s_zero_write;
    wr_flags && pwdata[7:0] == 8'h00 ##0 s_quiet;
  endsequence

  // Wake enable sits in a register the ports do not show: only a set with no cause is checked
  a_bad_sets: assert property (bad_msg_evt |=> fl[7])
    else $error("bad message flag missed");
  a_wake_needs_edge: assert property (!wr_flags && !fl[6] && can_rx |=> !fl[6])
    else $error("wake flag set with the bus idle");
  a_err_any: assert property ((|err_src_evt) |=> fl[5])
    else $error("module error flag missed");
  a_tx2_done: assert property (tx_done_evt[2] |=> fl[4])
    else $error("tx buffer 2 flag missed");
  a_tx1_done: assert property (tx_done_evt[1] |=> fl[3])
    else $error("tx buffer 1 flag missed");
  a_tx0_done: assert property (tx_done_evt[0] |=> fl[2])
    else $error("tx buffer 0 flag missed");
  a_rx1_full: assert property (rx_full_evt[1] |=> fl[1])
    else $error("rx buffer 1 flag missed");
  a_rx0_full: assert property (rx_full_evt[0] |=> fl[0])
    else $error("rx buffer 0 flag missed");
  a_flag_sticky: assert property (!wr_flags |=> (fl & $past(fl)) == $past(fl))
    else $error("flag dropped without a write");
  a_zero_clears: assert property (s_zero_write |=> (fl & 8'hbf) == 8'h00)
    else $error("zero write left a flag set");
endmodule // cif_flags_properties

bind cif_can_flags cif_flags_properties cif_flags_properties_i (
  .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .bad_msg_evt(bad_msg_evt),
  .can_rx(can_rx),
  .err_src_evt(err_src_evt), .tx_done_evt(tx_done_evt), .rx_full_evt(rx_full_evt),
  .can_event_flags(can_event_flags)
);

// [bench/cif_can_flags_tb.sv]
`timescale 1ns/1ps

module cif_can_flags_tb;
  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
  logic        can_rx, bad_msg_evt, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, strb;
  logic [4:0]  err_src_evt;
  logic [2:0]  tx_done_evt, tx_buf_free;
  logic [1:0]  rx_full_evt;
  logic [7:0]  can_event_flags, fl_exp;
  int          mismatches = 0, cmp_count = 0, cycles = 0;

  cif_can_flags cif_can_flags_i (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .bad_msg_evt(bad_msg_evt), .can_rx(can_rx),
    .err_src_evt(err_src_evt), .tx_done_evt(tx_done_evt), .rx_full_evt(rx_full_evt),
    .can_event_flags(can_event_flags), .tx_buf_free(tx_buf_free), .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Verdict, compares and bus tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A hung handshake would stall forever; the run is a few hundred cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask

  // Called just after a rising edge; one idle cycle follows so no signal is driven twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= strb;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), exp, rd);
  endtask

  task automatic pulse(input logic [10:0] v);
    {bad_msg_evt, err_src_evt, tx_done_evt, rx_full_evt} <= v;
    @(posedge clk_sys);
    {bad_msg_evt, err_src_evt, tx_done_evt, rx_full_evt} <= 11'h000;
    @(posedge clk_sys);
  endtask

  task automatic bus_low(input int n);
    can_rx <= 1'b0;
    repeat (n) @(posedge clk_sys);
    can_rx <= 1'b1;
    @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, bad_msg_evt, can_rx} = 5'h01;
    {paddr, pwdata, pstrb, strb} = {12'h000, 32'h0, 4'hf, 4'hf};
    {err_src_evt, tx_done_evt, rx_full_evt} = 10'h000;
    resetn = 1'b0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rdc(12'h000, 32'h0);
    rdc(12'h00c, 32'h1);
    chk_bit("irq", 1'b0, irq);
    for (int k = 0; k < 11; k++) begin
      wr(12'h000, 32'h0);
      pulse(11'h001 << k);
      fl_exp = 8'h01 << (k < 5 ? k : (k < 10 ? 5 : 7));
      rdc(12'h000, {24'h0, fl_exp});
      chk("tx_buf_free", {29'h0, fl_exp[4:2]}, {29'h0, tx_buf_free});
    end
    wr(12'h000, 32'h0);
    bus_low(1);
    rdc(12'h000, 32'h40);
    wr(12'h00c, 32'h0);
    wr(12'h000, 32'h0);
    bus_low(1);
    rdc(12'h000, 32'h0);
    // Filter on: four low cycles are a glitch, five are activity
    wr(12'h00c, 32'h3);
    bus_low(4);
    rdc(12'h000, 32'h0);
    bus_low(5);
    rdc(12'h000, 32'h40);
    wr(12'h00c, 32'h1);
    wr(12'h000, 32'hff);
    wr(12'h000, 32'h7f);
    rdc(12'h000, 32'h7f);
    strb = 4'he;
    wr(12'h000, 32'h0);
    strb = 4'hf;
    rdc(12'h000, 32'h7f);
    // Event lands on the edge where the clearing write takes effect (one wait state)
    fork
      wr(12'h000, 32'h0);
      begin
        repeat (2) @(posedge clk_sys);
        bad_msg_evt <= 1'b1;
        @(posedge clk_sys);
        bad_msg_evt <= 1'b0;
      end
    join
    rdc(12'h000, 32'h80);
    wr(12'h000, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    rdc(12'h010, 32'h1f);
    rdc(12'h010, 32'h0);
    wr(12'h008, 32'h08);
    rdc(12'h008, 32'h08);
    pulse(11'h004);
    chk_bit("irq masked", 1'b0, irq);
    pulse(11'h008);
    chk_bit("irq raised", 1'b1, irq);
    rdc(12'h004, 32'h0c);
    chk_bit("irq cleared", 1'b0, irq);
    rdc(12'h004, 32'h0);
    // Event taken while the status read waits must survive that read
    fork
      rdc(12'h004, 32'h0);
      begin
        @(posedge clk_sys);
        tx_done_evt <= 3'h4;
        @(posedge clk_sys);
        tx_done_evt <= 3'h0;
      end
    join
    rdc(12'h004, 32'h10);
    rdc(12'h020, 32'h0);
    chk_bit("pslverr", 1'b1, err);
    print_verdict();
  end
endmodule // cif_can_flags_tb
